// ==== verilog/sram_burst_pkg.sv ====
// shared constants, types and helpers of the flow-through burst sram block
// assumes a single clock domain; used by the top module and the burst generator
// =============================================================================
// sizes
package sram_burst_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 18;
	localparam int LANE_W = 9;
	localparam int LANES = 2;
	localparam int MEM_DEPTH = 256;
	localparam int BURST_W = 2;
	localparam int COUNT_W = 16;

	// =========================================================================
	// sleep timing, in clock cycles
	localparam int SLEEP_ENTRY_TIME_CYC = 2;
	localparam int SLEEP_RECOVERY_TIME_CYC = 2;
	localparam logic [1:0] SLEEP_ENTRY_CYCLES = 2'(SLEEP_ENTRY_TIME_CYC - 1);
	localparam logic [1:0] SLEEP_RECOVERY_CYCLES = 2'(SLEEP_RECOVERY_TIME_CYC - 1);

	// =========================================================================
	// wishbone register map
	localparam int WB_ADR_W = 4;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_ADDR = 4'h8;
	localparam logic [3:0] REG_COUNT = 4'hc;
	localparam int CTRL_DRIVE_BIT = 0;
	localparam logic CTRL_DRIVE_RESET = 1'b1;
	localparam int STAT_PEND_BIT = 0;
	localparam int STAT_STEP_LSB = 1;
	localparam int STAT_PWR_LSB = 3;
	localparam int STAT_IO_LSB = 5;
	localparam int STAT_ORDER_BIT = 7;
	localparam int COUNT_WR_LSB = 16;

	// =========================================================================
	// state machines
	typedef enum logic [1:0] {
		PWR_ACTIVE = 2'b00,
		PWR_ENTERING = 2'b01,
		PWR_ASLEEP = 2'b11,
		PWR_WAKING = 2'b10
	} power_state_t;

	typedef enum logic [1:0] {
		IO_DESELECT = 2'b00,
		IO_READ = 2'b01,
		IO_WRITE = 2'b11
	} io_state_t;

	// =========================================================================
	// low address bits for a given step of a burst
	function automatic logic [BURST_W-1:0] burst_low(input logic [BURST_W-1:0] start,
		input logic [BURST_W-1:0] step, input logic interleave);
		burst_low = interleave ? (start ^ step) : BURST_W'(start + step);
	endfunction

	// overlay enabled byte lanes of new data on old data
	function automatic logic [DATA_W-1:0] merge_lanes(input logic [DATA_W-1:0] old_word,
		input logic [DATA_W-1:0] new_word, input logic [LANES-1:0] lane_n);
		merge_lanes = old_word;
		for (int i = 0; i < LANES; i++) begin
			if (!lane_n[i]) begin
				merge_lanes[i*LANE_W +: LANE_W] = new_word[i*LANE_W +: LANE_W];
			end
		end
	endfunction
endpackage

// ==== verilog/burst_if.sv ====
// carrier between the top module and the burst address generator
// assumes both ends sit on the same clock
`timescale 1ns/1ps
// =============================================================================
// burst control bundle
interface burst_if;
	logic load;
	logic step;
	logic interleave;
	logic [sram_burst_pkg::BURST_W-1:0] start_low;
	logic [sram_burst_pkg::BURST_W-1:0] next_low;
	logic [sram_burst_pkg::BURST_W-1:0] step_count;

	modport gen(input load, input step, input interleave, input start_low, output next_low, output step_count);
	modport user(output load, output step, output interleave, output start_low, input next_low, input step_count);
endinterface

// ==== verilog/burst_addr_gen.sv ====
// two-bit burst address generator: start value, step count, order mode
// assumes load and step never come in the same cycle
`timescale 1ns/1ps
// =============================================================================
// generator
module burst_addr_gen (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// control from the top
	burst_if.gen bus
);
	logic [sram_burst_pkg::BURST_W-1:0] start;
	logic [sram_burst_pkg::BURST_W-1:0] count;
	logic mode;
	logic [sram_burst_pkg::BURST_W-1:0] next_count;

	// the step about to be used; two bits wrap after four accesses
	assign next_count = sram_burst_pkg::BURST_W'(count + 2'h1);
	assign bus.next_low = sram_burst_pkg::burst_low(start, next_count, mode);
	assign bus.step_count = count;

	// order is taken at load so a strap change mid-burst is not seen
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			start <= 2'h0;
			count <= 2'h0;
			mode <= 1'b0;
		end else if (bus.load) begin
			start <= bus.start_low;
			count <= 2'h0;
			mode <= bus.interleave;
		end else if (bus.step) begin
			count <= next_count;
		end
	end
endmodule

// ==== verilog/flow_through_sram_burst_sleep.sv ====
// flow-through single late write sram core with burst counter and sleep control
// assumes the controller drives pins on mclk; sleep_request and the order strap are asynchronous
// Behaviour
// - read to write needs no idle cycle
// - advance high steps counter, uses its address
// - advance low loads external start address
// - four addresses, fifth repeats the first
// - order pin low gives linear increment
// - order pin high gives xor interleave
// - sleep low or open means active
// - sleep entered two cycles after request, state kept; code sleeps on the fifth edge: two sync, one detect, two entry edges
// - normal operation two cycles after release; code takes reads from the fourth edge after release, writes from the sixth
// - asleep: deselected, inputs ignored, bus high-z
// - sleep request is asynchronous, active high
// - hold edge changes no io state
// - begin read decode from selects and strobes
// - address on one edge, write data next
// - write with no byte lane is aborted
// - stall keeps read driven, write high-z
`timescale 1ns/1ps
// =============================================================================
// top
module flow_through_sram_burst_sleep (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// synchronous command pins
	input wire logic clock_enable_n,
	input wire logic load_or_step_ctl,
	input wire logic write_enable_n,
	input wire logic [sram_burst_pkg::LANES-1:0] byte_lane_write_n,
	input wire logic chip_select_a_n,
	input wire logic chip_select_b,
	input wire logic chip_select_c_n,
	input wire logic [sram_burst_pkg::ADDR_W-1:0] address,
	// asynchronous pins
	input wire logic sleep_request,
	input wire logic burst_order_select_n,
	// data bus
	input wire logic [sram_burst_pkg::DATA_W-1:0] dq_in,
	output logic [sram_burst_pkg::DATA_W-1:0] dq_out,
	output logic dq_oe,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [sram_burst_pkg::WB_ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	// =========================================================================
	// storage and state
	logic [sram_burst_pkg::DATA_W-1:0] mem [sram_burst_pkg::MEM_DEPTH];
	sram_burst_pkg::power_state_t power_state;
	sram_burst_pkg::power_state_t next_power;
	sram_burst_pkg::io_state_t io_state;
	sram_burst_pkg::io_state_t next_io;
	logic [1:0] sleep_wait;
	logic [1:0] next_sleep_wait;
	logic sleep_sync1;
	logic sleep_sync2;
	logic order_sync1;
	logic order_sync2;
	logic [sram_burst_pkg::ADDR_W-1:sram_burst_pkg::BURST_W] addr_hi;
	logic wr_pend;
	logic [sram_burst_pkg::ADDR_W-1:0] wr_addr;
	logic [sram_burst_pkg::LANES-1:0] wr_lanes_n;
	logic drive_enable;
	logic [sram_burst_pkg::ADDR_W-1:0] last_addr;
	logic [sram_burst_pkg::COUNT_W-1:0] read_count;
	logic [sram_burst_pkg::COUNT_W-1:0] write_count;

	burst_if burst ();

	burst_addr_gen u_burst (
		.mclk(mclk),
		.rst_b(rst_b),
		.bus(burst.gen)
	);

	// =========================================================================
	// asynchronous pins: two flops each, the first read only by the second
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sleep_sync1 <= 1'b0;
			sleep_sync2 <= 1'b0;
			order_sync1 <= 1'b0;
			order_sync2 <= 1'b0;
		end else begin
			sleep_sync1 <= sleep_request;
			sleep_sync2 <= sleep_sync1;
			order_sync1 <= burst_order_select_n;
			order_sync2 <= order_sync1;
		end
	end

	// =========================================================================
	// command decode
	logic operational;
	logic waking;
	logic take;
	logic selected;
	logic any_lane;
	logic is_load;
	logic begin_read;
	logic begin_write;
	logic cont_read;
	logic cont_write;
	logic cont_any;
	logic do_read;
	logic do_write;
	logic do_load;
	logic do_step;
	logic [sram_burst_pkg::ADDR_W-1:0] access_addr;

	// sleep blocks the sram command pins; the sleep request and the wishbone pins stay live
	assign operational = (power_state != sram_burst_pkg::PWR_ASLEEP);
	assign waking = (power_state == sram_burst_pkg::PWR_WAKING);
	assign take = operational & ~clock_enable_n;
	assign selected = ~chip_select_a_n & chip_select_b & ~chip_select_c_n;
	assign any_lane = ~&byte_lane_write_n;
	assign is_load = ~load_or_step_ctl;
	assign begin_read = is_load & selected & write_enable_n;
	assign begin_write = is_load & selected & ~write_enable_n & any_lane;
	assign cont_any = load_or_step_ctl & (io_state != sram_burst_pkg::IO_DESELECT);
	assign cont_read = load_or_step_ctl & (io_state == sram_burst_pkg::IO_READ);
	assign cont_write = load_or_step_ctl & (io_state == sram_burst_pkg::IO_WRITE) & any_lane;
	assign do_read = take & (begin_read | cont_read);
	// writes during recovery are dropped as a safety net only
	assign do_write = take & (begin_write | cont_write) & ~waking;
	assign do_load = take & (begin_read | begin_write);
	assign do_step = take & cont_any;

	// counted address keeps the loaded upper bits
	assign access_addr = is_load ? address : {addr_hi, burst.next_low};

	// generator hookup
	assign burst.load = do_load;
	assign burst.step = do_step;
	assign burst.interleave = order_sync2;
	assign burst.start_low = address[sram_burst_pkg::BURST_W-1:0];

	// =========================================================================
	// io state: begin commands set the kind, continues keep it
	always_comb begin
		next_io = io_state;
		if (take && is_load) begin
			if (begin_read) begin
				next_io = sram_burst_pkg::IO_READ;
			end else if (begin_write) begin
				next_io = sram_burst_pkg::IO_WRITE;
			end else begin
				next_io = sram_burst_pkg::IO_DESELECT;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			io_state <= sram_burst_pkg::IO_DESELECT;
		end else begin
			io_state <= next_io;
		end
	end

	// =========================================================================
	// power state: entry and recovery each counted after the synchroniser
	always_comb begin
		next_power = power_state;
		next_sleep_wait = sleep_wait;
		case (power_state)
			sram_burst_pkg::PWR_ACTIVE: begin
				if (sleep_sync2) begin
					next_power = sram_burst_pkg::PWR_ENTERING;
					next_sleep_wait = 2'h0;
				end
			end
			sram_burst_pkg::PWR_ENTERING: begin
				if (!sleep_sync2) begin
					next_power = sram_burst_pkg::PWR_ACTIVE;
				end else if (sleep_wait == sram_burst_pkg::SLEEP_ENTRY_CYCLES) begin
					next_power = sram_burst_pkg::PWR_ASLEEP;
				end else begin
					next_sleep_wait = 2'(sleep_wait + 2'h1);
				end
			end
			sram_burst_pkg::PWR_ASLEEP: begin
				if (!sleep_sync2) begin
					next_power = sram_burst_pkg::PWR_WAKING;
					next_sleep_wait = 2'h0;
				end
			end
			sram_burst_pkg::PWR_WAKING: begin
				if (sleep_sync2) begin
					next_power = sram_burst_pkg::PWR_ASLEEP;
				end else if (sleep_wait == sram_burst_pkg::SLEEP_RECOVERY_CYCLES) begin
					next_power = sram_burst_pkg::PWR_ACTIVE;
				end else begin
					next_sleep_wait = 2'(sleep_wait + 2'h1);
				end
			end
			default: begin
				next_power = sram_burst_pkg::PWR_ACTIVE;
				next_sleep_wait = 2'h0;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			power_state <= sram_burst_pkg::PWR_ACTIVE;
			sleep_wait <= 2'h0;
		end else begin
			power_state <= next_power;
			sleep_wait <= next_sleep_wait;
		end
	end

	// =========================================================================
	// burst upper address, held across sleep
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			addr_hi <= '0;
		end else if (do_load) begin
			addr_hi <= address[sram_burst_pkg::ADDR_W-1:sram_burst_pkg::BURST_W];
		end
	end

	// =========================================================================
	// late write: address now, data at the next taken edge
	// a stalled or sleeping edge keeps the pending write, so nothing is lost
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			wr_pend <= 1'b0;
			wr_addr <= '0;
			wr_lanes_n <= '1;
		end else if (take) begin
			wr_pend <= do_write;
			if (do_write) begin
				wr_addr <= access_addr;
				wr_lanes_n <= byte_lane_write_n;
			end
		end
	end

	// array has no reset; contents survive sleep
	always_ff @(posedge mclk) begin
		if (take && wr_pend) begin
			mem[wr_addr] <= sram_burst_pkg::merge_lanes(mem[wr_addr], dq_in, wr_lanes_n);
		end
	end

	// =========================================================================
	// flow-through read with bypass of the write landing on the same edge
	logic [sram_burst_pkg::DATA_W-1:0] read_word;
	logic hit_pending;
	logic next_oe;

	assign hit_pending = wr_pend && (wr_addr == access_addr);
	assign read_word = hit_pending ? sram_burst_pkg::merge_lanes(mem[access_addr], dq_in, wr_lanes_n)
		: mem[access_addr];

	// a stall holds the bus as it was unless drive_enable is clear or sleep is entered; writes and aborts release it at once
	always_comb begin
		next_oe = dq_oe;
		if (next_power == sram_burst_pkg::PWR_ASLEEP || !operational) begin
			next_oe = 1'b0;
		end else if (take) begin
			next_oe = do_read & drive_enable;
		end else if (!drive_enable) begin
			next_oe = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			dq_oe <= 1'b0;
			dq_out <= '0;
		end else begin
			dq_oe <= next_oe;
			if (do_read) begin
				dq_out <= read_word;
			end
		end
	end

	// =========================================================================
	// activity record for software
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			last_addr <= '0;
		end else if (do_read || do_write) begin
			last_addr <= access_addr;
		end
	end

	// =========================================================================
	// wishbone slave: one wait state, ack for one cycle
	logic wb_req;
	logic wb_wr;
	logic ctrl_hit;
	logic count_clear;
	logic [31:0] status_word;
	logic [31:0] rd_word;

	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wb_wr = wb_req & wb_we_i;
	assign ctrl_hit = wb_wr & (wb_adr_i == sram_burst_pkg::REG_CTRL) & wb_sel_i[0];
	assign count_clear = wb_wr & (wb_adr_i == sram_burst_pkg::REG_COUNT);

	always_comb begin
		status_word = 32'h0;
		status_word[sram_burst_pkg::STAT_PEND_BIT] = wr_pend;
		status_word[sram_burst_pkg::STAT_STEP_LSB +: 2] = burst.step_count;
		status_word[sram_burst_pkg::STAT_PWR_LSB +: 2] = power_state;
		status_word[sram_burst_pkg::STAT_IO_LSB +: 2] = io_state;
		status_word[sram_burst_pkg::STAT_ORDER_BIT] = order_sync2;
	end

	// unmapped offsets read as zero
	always_comb begin
		case (wb_adr_i)
			sram_burst_pkg::REG_CTRL: rd_word = {31'h0, drive_enable};
			sram_burst_pkg::REG_STATUS: rd_word = status_word;
			sram_burst_pkg::REG_ADDR: rd_word = {24'h0, last_addr};
			sram_burst_pkg::REG_COUNT: rd_word = {write_count, read_count};
			default: rd_word = 32'h0;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
			drive_enable <= sram_burst_pkg::CTRL_DRIVE_RESET;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i) begin
				wb_dat_o <= rd_word;
			end
			if (ctrl_hit) begin
				drive_enable <= wb_dat_i[sram_burst_pkg::CTRL_DRIVE_BIT];
			end
		end
	end

	// counters: an access in the clearing cycle still counts
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			read_count <= '0;
			write_count <= '0;
		end else begin
			if (count_clear) begin
				read_count <= do_read ? 16'h0001 : 16'h0000;
			end else if (do_read) begin
				read_count <= 16'(read_count + 16'h0001);
			end
			if (count_clear) begin
				write_count <= do_write ? 16'h0001 : 16'h0000;
			end else if (do_write) begin
				write_count <= 16'(write_count + 16'h0001);
			end
		end
	end
endmodule

// ==== bench/sram_burst_chk.sv ====
// checker for the burst sram top: pin timing, sleep and wishbone answers
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
// =============================================================================
// checker
module sram_burst_chk (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// command pins
	input wire logic clock_enable_n,
	input wire logic load_or_step_ctl,
	input wire logic write_enable_n,
	input wire logic [sram_burst_pkg::LANES-1:0] byte_lane_write_n,
	input wire logic chip_select_a_n,
	input wire logic chip_select_b,
	input wire logic chip_select_c_n,
	input wire logic sleep_request,
	// data bus
	input wire logic [sram_burst_pkg::DATA_W-1:0] dq_out,
	input wire logic dq_oe,
	// wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [sram_burst_pkg::WB_ADR_W-1:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	logic [3:0] quiet;
	wire sel_begin = !clock_enable_n && !load_or_step_ctl && !chip_select_a_n && chip_select_b && !chip_select_c_n;
	// cycles since sleep fell; reads only judged once wake-up is long over
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			quiet <= 4'h0;
		end else if (sleep_request) begin
			quiet <= 4'h0;
		end else if (quiet != 4'hf) begin
			quiet <= quiet + 4'h1;
		end
	end
	// =========================================================================
	// properties
	property p_rd_drive; sel_begin && write_enable_n && quiet == 4'hf |=> dq_oe; endproperty
	a_rd_drive: assert property (p_rd_drive) else $error("read begin left bus undriven");
	property p_wr_hiz; sel_begin && !write_enable_n |=> !dq_oe; endproperty
	a_wr_hiz: assert property (p_wr_hiz) else $error("bus driven after write begin");
	property p_desel; !clock_enable_n && !load_or_step_ctl && chip_select_a_n |=> !dq_oe; endproperty
	a_desel: assert property (p_desel) else $error("bus driven after deselect");
	property p_stall;
		clock_enable_n && !sleep_request && !wb_cyc_i && quiet == 4'hf |=> $stable(dq_oe) && $stable(dq_out);
	endproperty
	a_stall: assert property (p_stall) else $error("stall edge changed the bus");
	// holds only while the bench keeps stalling through entry
	property p_sleep_entry; $rose(sleep_request) && dq_oe && clock_enable_n |-> dq_oe [*5] ##1 !dq_oe; endproperty
	a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry timing wrong");
	property p_sleep_hiz; sleep_request [*6] |-> !dq_oe; endproperty
	a_sleep_hiz: assert property (p_sleep_hiz) else $error("bus driven while asleep");
	property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("wishbone ack late");
	property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_once: assert property (p_ack_once) else $error("wishbone ack longer than one cycle");
	property p_unmapped; wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i[1:0] != 2'b00 |=> wb_dat_o == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped offset read nonzero");
	// main scenarios
	c_read: cover property (sel_begin && write_enable_n);
	c_abort: cover property (sel_begin && !write_enable_n && &byte_lane_write_n);
	c_sleep: cover property (sleep_request [*6]);
endmodule

// ==== bench/mem_ctl_model.sv ====
// memory controller model: drives sram commands, late write data and sleep
// assumes the bench calls op from one process, once per cycle
`timescale 1ns/1ps
// =============================================================================
// model
module mem_ctl_model (
	// clock
	input wire logic mclk,
	// command pins
	output logic clock_enable_n,
	output logic load_or_step_ctl,
	output logic write_enable_n,
	output logic [1:0] byte_lane_write_n,
	output logic chip_select_a_n,
	output logic chip_select_b,
	output logic chip_select_c_n,
	output logic [7:0] address,
	output logic sleep_request,
	// write data
	output logic [17:0] dq_in
);
	logic wr = 1'b0;
	logic pend = 1'b0;
	logic [17:0] pdat = 18'h0;
	// idle pins: deselected, stalled, awake
	initial begin
		clock_enable_n = 1'b1;
		load_or_step_ctl = 1'b0;
		write_enable_n = 1'b1;
		byte_lane_write_n = 2'b11;
		chip_select_a_n = 1'b1;
		chip_select_b = 1'b1;
		chip_select_c_n = 1'b0;
		address = 8'h0;
		sleep_request = 1'b0;
		dq_in = 18'h0;
	end
	// k: 0 deselect, 1 read, 2 write, 3 continue, 4 stall
	task automatic op(input int k, input logic [7:0] a, input logic [1:0] ln, input logic [17:0] d);
		@(posedge mclk);
		clock_enable_n <= (k == 4);
		if (k != 4) begin
			// a released data line flips so stale values never match
			dq_in <= pend ? pdat : ~dq_in;
			if (k < 3) begin
				wr = (k == 2) && ln != 2'b11;
			end
			pend = (k == 2 || (k == 3 && wr)) && ln != 2'b11;
			pdat = d;
			load_or_step_ctl <= (k == 3);
			write_enable_n <= (k != 2);
			byte_lane_write_n <= ln;
			chip_select_a_n <= (k == 0);
			address <= a;
		end
	endtask
	// sleep changes just after an edge, never with work pending
	task automatic sleep(input logic v);
		@(posedge mclk);
		sleep_request <= v;
	endtask
endmodule

// ==== bench/flow_through_sram_burst_sleep_tb.sv ====
// self-checking bench for the burst sram: bursts, abort, stall, sleep, registers
// assumes the controller model drives all sram pins but the order strap, which the bench drives, and the bench is wishbone master
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
	$display("ERROR %0t got %h exp %h", $time, a, b); end end
// =============================================================================
// bench
module flow_through_sram_burst_sleep_tb;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic burst_order_select_n = 1'b0;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hf;
	logic [31:0] wb_dat_i = 32'h0;
	wire clock_enable_n, load_or_step_ctl, write_enable_n, chip_select_a_n, chip_select_b, chip_select_c_n;
	wire sleep_request, dq_oe, wb_ack_o;
	wire [1:0] byte_lane_write_n;
	wire [7:0] address;
	wire [17:0] dq_in, dq_out;
	wire [31:0] wb_dat_o;
	int n_errors = 0;
	int checks_done = 0;
	logic [17:0] dv [4] = '{18'h0a5a5, 18'h35a5a, 18'h12345, 18'h2fedc};
	int ix [4] = '{2, 1, 0, 3};
	mem_ctl_model ctl (.mclk, .clock_enable_n, .load_or_step_ctl, .write_enable_n, .byte_lane_write_n,
		.chip_select_a_n, .chip_select_b, .chip_select_c_n, .address, .sleep_request, .dq_in);
	flow_through_sram_burst_sleep dut (.mclk, .rst_b, .clock_enable_n, .load_or_step_ctl, .write_enable_n,
		.byte_lane_write_n, .chip_select_a_n, .chip_select_b, .chip_select_c_n, .address, .sleep_request,
		.burst_order_select_n, .dq_in, .dq_out, .dq_oe, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o);
	// 10 MHz clock
	initial begin
		forever #50 mclk = ~mclk;
	end
	task automatic report_and_stop;
		if (n_errors == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// classic wishbone cycle; ack sampled at the rising edge, read data taken at that same edge
	task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge mclk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		for (n = 0; n < 20; n++) begin
			@(posedge mclk);
			if (wb_ack_o === 1'b1) break;
		end
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (n == 20) begin
			n_errors++;
			report_and_stop();
		end
	endtask
	// bus state after the edge at which op drove its pins, which took the command of the op before
	task automatic see(input logic oe, input logic [17:0] d);
		#1;
		`CHK(dq_oe, oe)
		if (oe) `CHK(dq_out, d)
	endtask
	// =========================================================================
	// main sequence
	initial begin
		logic [31:0] q;
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		wb(1'b0, sram_burst_pkg::REG_CTRL, 32'h0, q);
		`CHK(q, 32'h1)
		wb(1'b0, sram_burst_pkg::REG_STATUS, 32'h0, q);
		`CHK(q[4:3], 2'b00)
		wb(1'b0, 4'h2, 32'h0, q);
		`CHK(q, 32'h0)
		wb(1'b1, sram_burst_pkg::REG_CTRL, 32'h0, q);
		wb(1'b0, sram_burst_pkg::REG_CTRL, 32'h0, q);
		`CHK(q, 32'h0)
		wb(1'b1, sram_burst_pkg::REG_CTRL, 32'h1, q);
		// linear write burst from low bits 11, then read back with no idle cycle
		ctl.op(2, 8'h13, 2'b00, dv[0]);
		for (int i = 1; i < 4; i++) ctl.op(3, 8'hff, 2'b00, dv[i]);
		ctl.op(1, 8'h13, 2'b11, 18'h0);
		for (int i = 0; i < 5; i++) begin
			ctl.op(3, 8'hff, 2'b11, 18'h0);
			see(1'b1, dv[i % 4]);
		end
		ctl.op(4, 8'hff, 2'b11, 18'h0);
		see(1'b1, dv[1]);
		ctl.op(0, 8'h0, 2'b11, 18'h0);
		see(1'b1, dv[1]);
		ctl.op(1, 8'h10, 2'b11, 18'h0);
		see(1'b0, 18'h0);
		ctl.op(0, 8'h0, 2'b11, 18'h0);
		see(1'b1, dv[1]);
		// interleaved order from low bits 01
		burst_order_select_n <= 1'b1;
		repeat (4) ctl.op(0, 8'h0, 2'b11, 18'h0);
		ctl.op(1, 8'h11, 2'b11, 18'h0);
		for (int i = 0; i < 4; i++) begin
			ctl.op(3, 8'hff, 2'b11, 18'h0);
			see(1'b1, dv[ix[i]]);
		end
		// write abort, then one lane written and read back at once
		ctl.op(2, 8'h10, 2'b11, 18'h3ffff);
		ctl.op(1, 8'h10, 2'b11, 18'h0);
		see(1'b0, 18'h0);
		ctl.op(2, 8'h10, 2'b10, 18'h3ffff);
		see(1'b1, dv[1]);
		ctl.op(1, 8'h10, 2'b11, 18'h0);
		ctl.op(0, 8'h0, 2'b11, 18'h0);
		see(1'b1, {dv[1][17:9], 9'h1ff});
		// sleep during a stalled read: two sync edges, one detect edge, then two entry edges
		ctl.op(1, 8'h11, 2'b11, 18'h0);
		ctl.op(4, 8'h0, 2'b11, 18'h0);
		see(1'b1, dv[2]);
		ctl.sleep(1'b1);
		repeat (4) @(posedge mclk);
		see(1'b1, dv[2]);
		@(posedge mclk);
		see(1'b0, 18'h0);
		ctl.op(1, 8'h12, 2'b11, 18'h0);
		ctl.op(0, 8'h0, 2'b11, 18'h0);
		see(1'b0, 18'h0);
		wb(1'b0, sram_burst_pkg::REG_STATUS, 32'h0, q);
		`CHK(q[4:3], 2'b11)
		ctl.sleep(1'b0);
		repeat (8) ctl.op(0, 8'h0, 2'b11, 18'h0);
		ctl.op(1, 8'h11, 2'b11, 18'h0);
		ctl.op(0, 8'h0, 2'b11, 18'h0);
		see(1'b1, dv[2]);
		wb(1'b0, sram_burst_pkg::REG_ADDR, 32'h0, q);
		`CHK(q, 32'h11)
		report_and_stop();
	end
endmodule
bind flow_through_sram_burst_sleep sram_burst_chk chk (.mclk, .rst_b, .clock_enable_n, .load_or_step_ctl,
	.write_enable_n, .byte_lane_write_n, .chip_select_a_n, .chip_select_b, .chip_select_c_n, .sleep_request,
	.dq_out, .dq_oe, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o);
